// [core/fbgp_map.svh]
`ifndef FBGP_MAP_SVH
`define FBGP_MAP_SVH

// ----------------------------------------------------------------
// data memory port register offsets
// ----------------------------------------------------------------
`define FBGP_DM_OFS_70 7'h70
`define FBGP_DM_OFS_71 7'h71
`define FBGP_DM_OFS_72 7'h72
`define FBGP_DM_OFS_73 7'h73

// ----------------------------------------------------------------
// bank codes
// ----------------------------------------------------------------
`define FBGP_BANK0 2'h0
`define FBGP_BANK1 2'h1
`define FBGP_BANK2 2'h2

// ----------------------------------------------------------------
// control register file offsets
// ----------------------------------------------------------------
`define FBGP_RF_GROUP_DIR 7'h27
`define FBGP_RF_THIRD_DIR 7'h35
`define FBGP_RF_SECOND_DIR 7'h36
`define FBGP_RF_FIRST_DIR 7'h37

// ----------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------
`define FBGP_DIR_RST 4'h0
`define FBGP_LATCH_RST 4'h0
`define FBGP_GROUP_LATCH_RST 3'h0
`define FBGP_GROUP_DIR_RST 1'b0
`define FBGP_NIB_ZERO 4'h0
`define FBGP_GROUP_DIR_BIT 0
`define FBGP_PIN_LEVEL_MASK 4'h3

`endif

// [core/fbgp_pkg.sv]
package fbgp_pkg;

  // data memory access from the cpu
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] bank;
    logic [6:0] addr;
    logic [3:0] wdata;
  } fbgp_dm_req_t;

  // control register file access from the cpu
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [3:0] wdata;
  } fbgp_rf_req_t;

  // raw pin levels of every port that can be read
  typedef struct packed {
    logic [3:0] first;
    logic [3:0] second;
    logic [3:0] third;
    logic [2:0] grouped;
    logic [3:0] input_only;
  } fbgp_pin_in_t;

  // drive of one four pin bidirectional port
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } fbgp_bidir_drv_t;

  // drive of the three pin grouped port
  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } fbgp_group_drv_t;

endpackage : fbgp_pkg

// [core/fbgp_ports.sv]
// Functional notes
// - first bidir port pin directions come from per-bit register at 37H.
// - second bidir port pin directions come from per-bit register at 36H.
// - third bidir port pin directions come from per-bit register at 35H.
// - grouped port direction comes from the group register at 27H.
// - first bidir port data at 70H, same register in banks 0 and 2.
// - second bidir port data at 71H, same register in banks 0 and 2.
// - third bidir port data at 71H in bank 1.
// - grouped port data at 72H in bank 1.
// - input-only port pin levels are read at 73H in banks 0 and 2.
// - first output latch at 72H banks 0/2; second at 70H bank 1.
// - grouped port uses bits 3..1; bit 0 has no pin, reads zero.
// - each pin of the three four-bit ports has its own direction.
// - the grouped port's three pins switch direction together.
// - writes update latches; reads sample the pins through two sync flops.
// - an input pin floats; reading returns its level, high as 1.
// - writing a port set as input still updates its output latch.
// - output pins read the latch, except first port pins 1..0 read level.
// - all resets and clock stop make pins input; ce reset keeps latches.
`timescale 1ns/100ps
`include "fbgp_map.svh"

module fbgp_ports (
  // clock and resets
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce_reset,
  input wire logic clock_stop,
  // cpu data memory access
  input wire fbgp_pkg::fbgp_dm_req_t dm_req,
  output logic [3:0] dm_rdata,
  output logic dm_rvalid,
  // cpu control register file access
  input wire fbgp_pkg::fbgp_rf_req_t rf_req,
  output logic [3:0] rf_rdata,
  output logic rf_rvalid,
  // pin levels
  input wire fbgp_pkg::fbgp_pin_in_t pin_in,
  // bidirectional pin drive
  output fbgp_pkg::fbgp_bidir_drv_t first_bidir_port,
  output fbgp_pkg::fbgp_bidir_drv_t second_bidir_port,
  output fbgp_pkg::fbgp_bidir_drv_t third_bidir_port,
  output fbgp_pkg::fbgp_group_drv_t grouped_bidir_port,
  // output-only pins
  output logic [3:0] first_output_port,
  output logic [3:0] second_output_port
);
  import fbgp_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // banks 0 and 2 alias the same port registers
  function automatic logic in_bank_02(input logic [1:0] bank);
    in_bank_02 = (bank == `FBGP_BANK0) || (bank == `FBGP_BANK2);
  endfunction : in_bank_02

  function automatic logic in_bank_1(input logic [1:0] bank);
    in_bank_1 = (bank == `FBGP_BANK1);
  endfunction : in_bank_1

  // output bits return the latch, input bits the pin level
  function automatic logic [3:0] mix_read(
    input logic [3:0] latch,
    input logic [3:0] dir,
    input logic [3:0] level
  );
    mix_read = (latch & dir) | (level & ~dir);
  endfunction : mix_read

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  fbgp_pin_in_t meta_reg;
  fbgp_pin_in_t meta_next;
  fbgp_pin_in_t level_reg;
  fbgp_pin_in_t level_next;

  always_comb begin
    meta_next = pin_in;
    level_next = meta_reg;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      level_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      level_reg <= level_next;
    end
  end

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic dm_b02;
  logic dm_b1;
  logic hit_70_b02;
  logic hit_71_b02;
  logic hit_72_b02;
  logic hit_73_b02;
  logic hit_70_b1;
  logic hit_71_b1;
  logic hit_72_b1;
  logic dir_reset;

  always_comb begin
    dm_b02 = in_bank_02(dm_req.bank);
    dm_b1 = in_bank_1(dm_req.bank);
    hit_70_b02 = dm_b02 && (dm_req.addr == `FBGP_DM_OFS_70);
    hit_71_b02 = dm_b02 && (dm_req.addr == `FBGP_DM_OFS_71);
    hit_72_b02 = dm_b02 && (dm_req.addr == `FBGP_DM_OFS_72);
    hit_73_b02 = dm_b02 && (dm_req.addr == `FBGP_DM_OFS_73);
    hit_70_b1 = dm_b1 && (dm_req.addr == `FBGP_DM_OFS_70);
    hit_71_b1 = dm_b1 && (dm_req.addr == `FBGP_DM_OFS_71);
    hit_72_b1 = dm_b1 && (dm_req.addr == `FBGP_DM_OFS_72);
    // ce reset and clock stop act like power-on on the directions only
    dir_reset = ce_reset || clock_stop;
  end

  // ----------------------------------------------------------------
  // direction selection registers
  // ----------------------------------------------------------------
  logic [3:0] first_port_direction_bits_reg;
  logic [3:0] first_port_direction_bits_next;
  logic [3:0] second_port_direction_bits_reg;
  logic [3:0] second_port_direction_bits_next;
  logic [3:0] third_port_direction_bits_reg;
  logic [3:0] third_port_direction_bits_next;
  logic grouped_port_direction_reg;
  logic grouped_port_direction_next;

  always_comb begin
    first_port_direction_bits_next = first_port_direction_bits_reg;
    second_port_direction_bits_next = second_port_direction_bits_reg;
    third_port_direction_bits_next = third_port_direction_bits_reg;
    grouped_port_direction_next = grouped_port_direction_reg;
    if (dir_reset) begin
      first_port_direction_bits_next = `FBGP_DIR_RST;
      second_port_direction_bits_next = `FBGP_DIR_RST;
      third_port_direction_bits_next = `FBGP_DIR_RST;
      grouped_port_direction_next = `FBGP_GROUP_DIR_RST;
    end else if (rf_req.wr) begin
      case (rf_req.addr)
        `FBGP_RF_FIRST_DIR: begin
          first_port_direction_bits_next = rf_req.wdata;
        end
        `FBGP_RF_SECOND_DIR: begin
          second_port_direction_bits_next = rf_req.wdata;
        end
        `FBGP_RF_THIRD_DIR: begin
          third_port_direction_bits_next = rf_req.wdata;
        end
        `FBGP_RF_GROUP_DIR: begin
          grouped_port_direction_next = rf_req.wdata[`FBGP_GROUP_DIR_BIT];
        end
        default: begin
          // other register file cells live outside this block
          grouped_port_direction_next = grouped_port_direction_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_port_direction_bits_reg <= `FBGP_DIR_RST;
      second_port_direction_bits_reg <= `FBGP_DIR_RST;
      third_port_direction_bits_reg <= `FBGP_DIR_RST;
      grouped_port_direction_reg <= `FBGP_GROUP_DIR_RST;
    end else begin
      first_port_direction_bits_reg <= first_port_direction_bits_next;
      second_port_direction_bits_reg <= second_port_direction_bits_next;
      third_port_direction_bits_reg <= third_port_direction_bits_next;
      grouped_port_direction_reg <= grouped_port_direction_next;
    end
  end

  // ----------------------------------------------------------------
  // output latches
  // ----------------------------------------------------------------
  // latches are written regardless of direction and survive ce reset
  logic [3:0] first_latch_reg;
  logic [3:0] first_latch_next;
  logic [3:0] second_latch_reg;
  logic [3:0] second_latch_next;
  logic [3:0] third_latch_reg;
  logic [3:0] third_latch_next;
  logic [2:0] group_latch_reg;
  logic [2:0] group_latch_next;
  logic [3:0] out0_latch_reg;
  logic [3:0] out0_latch_next;
  logic [3:0] out1_latch_reg;
  logic [3:0] out1_latch_next;

  always_comb begin
    first_latch_next = first_latch_reg;
    second_latch_next = second_latch_reg;
    third_latch_next = third_latch_reg;
    group_latch_next = group_latch_reg;
    out0_latch_next = out0_latch_reg;
    out1_latch_next = out1_latch_reg;
    if (dm_req.wr) begin
      if (hit_70_b02) begin
        first_latch_next = dm_req.wdata;
      end
      if (hit_71_b02) begin
        second_latch_next = dm_req.wdata;
      end
      if (hit_71_b1) begin
        third_latch_next = dm_req.wdata;
      end
      if (hit_72_b1) begin
        // bit 0 has no pin, so it is simply dropped
        group_latch_next = dm_req.wdata[3:1];
      end
      if (hit_72_b02) begin
        out0_latch_next = dm_req.wdata;
      end
      if (hit_70_b1) begin
        out1_latch_next = dm_req.wdata;
      end
      // the input-only port at 73H ignores writes
    end
  end

  // only power-on clears the latches; software must not count on it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_latch_reg <= `FBGP_LATCH_RST;
      second_latch_reg <= `FBGP_LATCH_RST;
      third_latch_reg <= `FBGP_LATCH_RST;
      group_latch_reg <= `FBGP_GROUP_LATCH_RST;
      out0_latch_reg <= `FBGP_LATCH_RST;
      out1_latch_reg <= `FBGP_LATCH_RST;
    end else begin
      first_latch_reg <= first_latch_next;
      second_latch_reg <= second_latch_next;
      third_latch_reg <= third_latch_next;
      group_latch_reg <= group_latch_next;
      out0_latch_reg <= out0_latch_next;
      out1_latch_reg <= out1_latch_next;
    end
  end

  // ----------------------------------------------------------------
  // data memory read path
  // ----------------------------------------------------------------
  logic [3:0] group_dir4;
  logic [3:0] first_dir_rd;
  logic [3:0] dm_rdata_reg;
  logic [3:0] dm_rdata_next;
  logic dm_rvalid_reg;
  logic dm_rvalid_next;

  always_comb begin
    group_dir4 = {4{grouped_port_direction_reg}};
    // low two pins of the first port always return the pin level
    first_dir_rd = first_port_direction_bits_reg & ~`FBGP_PIN_LEVEL_MASK;
    dm_rvalid_next = dm_req.rd;
    dm_rdata_next = dm_rdata_reg;
    if (dm_req.rd) begin
      dm_rdata_next = `FBGP_NIB_ZERO;
      if (hit_70_b02) begin
        dm_rdata_next = mix_read(first_latch_reg, first_dir_rd, level_reg.first);
      end
      if (hit_71_b02) begin
        dm_rdata_next = mix_read(second_latch_reg, second_port_direction_bits_reg,
          level_reg.second);
      end
      if (hit_71_b1) begin
        dm_rdata_next = mix_read(third_latch_reg, third_port_direction_bits_reg,
          level_reg.third);
      end
      if (hit_72_b1) begin
        dm_rdata_next = mix_read({group_latch_reg, 1'b0}, group_dir4,
          {level_reg.grouped, 1'b0});
      end
      if (hit_72_b02) begin
        dm_rdata_next = out0_latch_reg;
      end
      if (hit_70_b1) begin
        dm_rdata_next = out1_latch_reg;
      end
      if (hit_73_b02) begin
        dm_rdata_next = level_reg.input_only;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dm_rdata_reg <= `FBGP_NIB_ZERO;
      dm_rvalid_reg <= 1'b0;
    end else begin
      dm_rdata_reg <= dm_rdata_next;
      dm_rvalid_reg <= dm_rvalid_next;
    end
  end

  // ----------------------------------------------------------------
  // register file read path
  // ----------------------------------------------------------------
  logic [3:0] rf_rdata_reg;
  logic [3:0] rf_rdata_next;
  logic rf_rvalid_reg;
  logic rf_rvalid_next;

  always_comb begin
    rf_rvalid_next = rf_req.rd;
    rf_rdata_next = rf_rdata_reg;
    if (rf_req.rd) begin
      case (rf_req.addr)
        `FBGP_RF_FIRST_DIR: begin
          rf_rdata_next = first_port_direction_bits_reg;
        end
        `FBGP_RF_SECOND_DIR: begin
          rf_rdata_next = second_port_direction_bits_reg;
        end
        `FBGP_RF_THIRD_DIR: begin
          rf_rdata_next = third_port_direction_bits_reg;
        end
        `FBGP_RF_GROUP_DIR: begin
          rf_rdata_next = {3'h0, grouped_port_direction_reg};
        end
        default: begin
          rf_rdata_next = `FBGP_NIB_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rf_rdata_reg <= `FBGP_NIB_ZERO;
      rf_rvalid_reg <= 1'b0;
    end else begin
      rf_rdata_reg <= rf_rdata_next;
      rf_rvalid_reg <= rf_rvalid_next;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // enables come straight from the direction flops, so a reset floats
  // the pins in the same edge that clears them
  always_comb begin
    first_bidir_port.out = first_latch_reg;
    first_bidir_port.oe = first_port_direction_bits_reg;
    second_bidir_port.out = second_latch_reg;
    second_bidir_port.oe = second_port_direction_bits_reg;
    third_bidir_port.out = third_latch_reg;
    third_bidir_port.oe = third_port_direction_bits_reg;
    grouped_bidir_port.out = group_latch_reg;
    grouped_bidir_port.oe = {3{grouped_port_direction_reg}};
    first_output_port = out0_latch_reg;
    second_output_port = out1_latch_reg;
    dm_rdata = dm_rdata_reg;
    dm_rvalid = dm_rvalid_reg;
    rf_rdata = rf_rdata_reg;
    rf_rvalid = rf_rvalid_reg;
  end

endmodule : fbgp_ports

// [tb/fbgp_pin_env.sv]
`timescale 1ns/100ps

module fbgp_pin_env (
  // drive from the ports
  input wire fbgp_pkg::fbgp_bidir_drv_t f_drv,
  input wire fbgp_pkg::fbgp_bidir_drv_t s_drv,
  input wire fbgp_pkg::fbgp_bidir_drv_t t_drv,
  input wire fbgp_pkg::fbgp_group_drv_t g_drv,
  // outside circuit levels and a hard pull-down on first port pins
  input wire fbgp_pkg::fbgp_pin_in_t ext,
  input wire logic [3:0] first_clamp,
  // resolved wire levels
  output fbgp_pkg::fbgp_pin_in_t pin_in
);
  import fbgp_pkg::*;

  // a driven pin shows the latch, a floating one the outside level, unless first_clamp holds a first port pin low
  always_comb begin
    pin_in = ext;
    pin_in.first = ((f_drv.oe & f_drv.out) | (~f_drv.oe & ext.first)) & ~first_clamp;
    pin_in.second = (s_drv.oe & s_drv.out) | (~s_drv.oe & ext.second);
    pin_in.third = (t_drv.oe & t_drv.out) | (~t_drv.oe & ext.third);
    pin_in.grouped = (g_drv.oe & g_drv.out) | (~g_drv.oe & ext.grouped);
  end
endmodule : fbgp_pin_env

// [tb/fbgp_ports_sva.sv]
`timescale 1ns/100ps

module fbgp_ports_sva (
  // clock and resets
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce_reset,
  input wire logic clock_stop,
  // cpu side
  input wire fbgp_pkg::fbgp_dm_req_t dm_req,
  input wire logic [3:0] dm_rdata,
  input wire logic dm_rvalid,
  input wire fbgp_pkg::fbgp_rf_req_t rf_req,
  // pin side
  input wire fbgp_pkg::fbgp_bidir_drv_t first_bidir_port,
  input wire fbgp_pkg::fbgp_bidir_drv_t second_bidir_port,
  input wire fbgp_pkg::fbgp_bidir_drv_t third_bidir_port,
  input wire fbgp_pkg::fbgp_group_drv_t grouped_bidir_port,
  input wire logic [3:0] first_output_port
);
  import fbgp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic rf_ok;
  logic dm_b02;
  // direction writes count only outside ce reset and clock stop
  assign rf_ok = rf_req.wr && !ce_reset && !clock_stop;
  assign dm_b02 = (dm_req.bank == 2'h0) || (dm_req.bank == 2'h2);

  AST_DM_RVALID: assert property (dm_req.rd |=> dm_rvalid)
    else $error("read not answered one cycle later");
  AST_DM_NO_RVALID: assert property (!dm_req.rd |=> !dm_rvalid)
    else $error("read answer without a read");
  AST_DIR_CLEAR: assert property ((ce_reset || clock_stop) |=>
    (first_bidir_port.oe | second_bidir_port.oe | third_bidir_port.oe) == 4'h0 && grouped_bidir_port.oe == 3'h0)
    else $error("pins still driven after ce reset or clock stop");
  AST_GROUP_ONE: assert property (grouped_bidir_port.oe == 3'h0 || grouped_bidir_port.oe == 3'h7)
    else $error("grouped pins split in direction");
  AST_FIRST_DIR: assert property (rf_ok && rf_req.addr == 7'h37 |=>
    first_bidir_port.oe == $past(rf_req.wdata)) else $error("first port direction wrong");
  AST_GROUP_DIR: assert property (rf_ok && rf_req.addr == 7'h27 |=>
    grouped_bidir_port.oe == {3{$past(rf_req.wdata[0])}}) else $error("grouped direction wrong");
  AST_FIRST_LATCH: assert property (dm_req.wr && dm_b02 && dm_req.addr == 7'h70 |=>
    first_bidir_port.out == $past(dm_req.wdata)) else $error("first port latch wrong");
  AST_OUT_PORT: assert property (dm_req.wr && dm_b02 && dm_req.addr == 7'h72 |=>
    first_output_port == $past(dm_req.wdata)) else $error("first output latch wrong");
  AST_GROUP_BIT0: assert property (dm_req.rd && dm_req.bank == 2'h1 && dm_req.addr == 7'h72 |=>
    dm_rdata[0] == 1'b0) else $error("grouped bit 0 not zero");
endmodule : fbgp_ports_sva

bind fbgp_ports fbgp_ports_sva u_sva (.clk, .rstn, .ce_reset, .clock_stop, .dm_req, .dm_rdata, .dm_rvalid,
  .rf_req, .first_bidir_port, .second_bidir_port, .third_bidir_port, .grouped_bidir_port, .first_output_port);

// [tb/fbgp_ports_tb.sv]
`timescale 1ns/100ps

module fbgp_ports_tb;
  import fbgp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce_reset = 1'b0;
  logic clock_stop = 1'b0;
  fbgp_dm_req_t dm_req = '0;
  fbgp_rf_req_t rf_req = '0;
  fbgp_pin_in_t ext = '0;
  logic [3:0] first_clamp = 4'h0;
  fbgp_pin_in_t pin_in;
  logic [3:0] dm_rdata;
  logic dm_rvalid;
  logic [3:0] rf_rdata;
  logic rf_rvalid;
  fbgp_bidir_drv_t first_bidir_port;
  fbgp_bidir_drv_t second_bidir_port;
  fbgp_bidir_drv_t third_bidir_port;
  fbgp_group_drv_t grouped_bidir_port;
  logic [3:0] first_output_port;
  logic [3:0] second_output_port;
  int num_errors = 0;
  int compares = 0;

  always #2.5 clk = ~clk;

  fbgp_ports uut (.clk, .rstn, .ce_reset, .clock_stop, .dm_req, .dm_rdata, .dm_rvalid, .rf_req, .rf_rdata,
    .rf_rvalid, .pin_in, .first_bidir_port, .second_bidir_port, .third_bidir_port, .grouped_bidir_port,
    .first_output_port, .second_output_port);
  fbgp_pin_env env (.f_drv(first_bidir_port), .s_drv(second_bidir_port), .t_drv(third_bidir_port),
    .g_drv(grouped_bidir_port), .ext(ext), .first_clamp(first_clamp), .pin_in(pin_in));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // one access on either bus; a read compares its answer with d
  task automatic acc(input logic rf, input logic wr, input logic [1:0] b, input logic [6:0] a,
                     input logic [3:0] d);
    int i;
    @(posedge clk) #1;
    if (rf) rf_req = '{wr: wr, rd: !wr, addr: a, wdata: d};
    else dm_req = '{wr: wr, rd: !wr, bank: b, addr: a, wdata: d};
    @(posedge clk) #1;
    rf_req = '0;
    dm_req = '0;
    if (!wr) begin
      for (i = 0; i < 4 && (rf ? rf_rvalid : dm_rvalid) !== 1'b1; i++) @(posedge clk) #1;
      if (i == 4) begin
        num_errors++;
        print_verdict();
      end
      check(rf ? rf_rdata : dm_rdata, d);
    end
  endtask : acc

  task automatic t_dir();
    check(first_bidir_port.oe | second_bidir_port.oe | third_bidir_port.oe, 4'h0);
    check({1'b0, grouped_bidir_port.oe}, 4'h0);
    acc(1, 1, 2'h0, 7'h37, 4'h5);
    acc(1, 1, 2'h0, 7'h36, 4'hA);
    acc(1, 1, 2'h0, 7'h35, 4'h6);
    check(first_bidir_port.oe, 4'h5);
    check(second_bidir_port.oe, 4'hA);
    check(third_bidir_port.oe, 4'h6);
    acc(1, 1, 2'h0, 7'h27, 4'hF);
    check({1'b0, grouped_bidir_port.oe}, 4'h7);
    acc(1, 0, 2'h0, 7'h27, 4'h1);
    acc(1, 0, 2'h0, 7'h36, 4'hA);
    acc(1, 1, 2'h0, 7'h27, 4'hE);
    check({1'b0, grouped_bidir_port.oe}, 4'h0);
    $display("test directions done");
  endtask : t_dir

  task automatic t_data();
    acc(0, 1, 2'h0, 7'h70, 4'h9);
    acc(0, 1, 2'h2, 7'h71, 4'h3);
    acc(0, 1, 2'h1, 7'h71, 4'h7);
    acc(0, 1, 2'h1, 7'h72, 4'hF);
    acc(0, 1, 2'h0, 7'h72, 4'hB);
    acc(0, 1, 2'h1, 7'h70, 4'h4);
    check(first_bidir_port.out, 4'h9);
    check(second_bidir_port.out, 4'h3);
    check(third_bidir_port.out, 4'h7);
    check({1'b0, grouped_bidir_port.out}, 4'h7);
    check(first_output_port, 4'hB);
    check(second_output_port, 4'h4);
    acc(0, 0, 2'h2, 7'h72, 4'hB);
    acc(0, 0, 2'h1, 7'h70, 4'h4);
    // bit 0 is driven high but held low outside, so it reads low
    acc(0, 0, 2'h2, 7'h70, 4'hA);
    acc(0, 0, 2'h0, 7'h71, 4'h6);
    acc(0, 0, 2'h1, 7'h71, 4'hE);
    acc(0, 0, 2'h1, 7'h72, 4'hA);
    acc(1, 1, 2'h0, 7'h27, 4'h1);
    acc(0, 0, 2'h1, 7'h72, 4'hE);
    $display("test data done");
  endtask : t_data

  task automatic t_input();
    acc(0, 0, 2'h0, 7'h73, 4'h6);
    acc(0, 1, 2'h0, 7'h73, 4'h0);
    ext.input_only = 4'h9;
    // two sync flops sit between the pin and the read
    repeat (3) @(posedge clk);
    #1;
    acc(0, 0, 2'h2, 7'h73, 4'h9);
    $display("test input port done");
  endtask : t_input

  task automatic t_ce();
    ce_reset = 1'b1;
    acc(1, 1, 2'h0, 7'h37, 4'hF);
    ce_reset = 1'b0;
    check(first_bidir_port.oe | second_bidir_port.oe | third_bidir_port.oe, 4'h0);
    check({1'b0, grouped_bidir_port.oe}, 4'h0);
    check(first_bidir_port.out, 4'h9);
    acc(1, 0, 2'h0, 7'h37, 4'h0);
    acc(1, 1, 2'h0, 7'h37, 4'h3);
    acc(1, 1, 2'h0, 7'h27, 4'h1);
    clock_stop = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    clock_stop = 1'b0;
    check(first_bidir_port.oe | {1'b0, grouped_bidir_port.oe}, 4'h0);
    check(third_bidir_port.out, 4'h7);
    check(first_output_port, 4'hB);
    acc(1, 1, 2'h0, 7'h27, 4'h1);
    acc(1, 0, 2'h0, 7'h27, 4'h1);
    acc(1, 0, 2'h0, 7'h10, 4'h0);
    acc(0, 0, 2'h1, 7'h70, 4'h4);
    acc(0, 0, 2'h3, 7'h70, 4'h0);
    $display("test ce reset and clock stop done");
  endtask : t_ce

  initial begin
    ext = '{first: 4'hA, second: 4'hC, third: 4'h8, grouped: 3'h5, input_only: 4'h6};
    first_clamp = 4'h1;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_dir();
    t_data();
    t_input();
    t_ce();
    print_verdict();
  end
endmodule : fbgp_ports_tb
